// >>> design/rfpmc_params.svh
// Offsets, field positions, reset values and codes of the protocol mode registers
// Notes on behaviour
// [RULE_01] Role bit: 0 initiator, 1 target; mode field decodes per role.
// [RULE_02] Initiator codes 0,1,2,3,4,E,F select the listed protocols; others unused.
// [RULE_03] Target code 0 is active with rate detection, code 1 active normal.
// [RULE_04] An unsupported role and mode combination disables transmit and receive.
// [RULE_05] With auto bit set, external field loss starts response collision avoidance.
// [RULE_06] All three registers default at reset and set-default; only mode bit 3 is 1.
// [RULE_07] Rate register upper nibble is transmit rate, lower nibble receive rate.
// [RULE_08] Separate receive rate applies only where the protocol allows differing rates.
// [RULE_09] Rate codes 0..3 give fc/128, fc/64, fc/32, fc/16; others unused.
// [RULE_10] An unsupported rate code disables transmit and receive.
// [RULE_11] The normal NFC entry command loads the rate register.
// [RULE_12] Transmit parity suppress sends buffer data with no parity bits.
// [RULE_13] Host starts such a transmission with the transmit-without-CRC command.
// [RULE_14] Receive parity suppress stores raw bits, checks neither parity nor CRC.
// [RULE_15] Transport frame bit in active NFC mode adds F0 and length, drops F0.
// [RULE_16] Pulse length field, bits 4..1, sets modulation width in carrier periods.
// [RULE_17] Host sets the anticollision bit before a bit-oriented anticollision frame.
// [RULE_18] Pulse code maps to periods by rate; code 0 gives 35 at fc/128, 5 at fc/16.
// [RULE_19] Mode bits 2 and 1 read zero and ignore writes.
`ifndef RFPMC_PARAMS_SVH
`define RFPMC_PARAMS_SVH

`define RFPMC_IDX_MODE        6'h03
`define RFPMC_IDX_RATE        6'h04
`define RFPMC_IDX_TYPEA       6'h05
`define RFPMC_ADDR_MODE       8'h0C
`define RFPMC_ADDR_RATE       8'h10
`define RFPMC_ADDR_TYPEA      8'h14

`define RFPMC_MODE_RST        8'h08
`define RFPMC_RATE_RST        8'h00
`define RFPMC_TYPEA_RST       8'h00
`define RFPMC_MODE_WMASK      8'hF9

`define RFPMC_MODE_ROLE_BIT   7
`define RFPMC_MODE_AUTO_BIT   0
`define RFPMC_TA_NOTXPAR_BIT  7
`define RFPMC_TA_NORXPAR_BIT  6
`define RFPMC_TA_TFRAME_BIT   5
`define RFPMC_TA_ANTCL_BIT    0

`define RFPMC_RATE_MAX        4'h3
`define RFPMC_START_BYTE      8'hF0

`define RFPMC_PW_BASE_128     6'h23
`define RFPMC_PW_BASE_64      6'h12
`define RFPMC_PW_BASE_32      6'h09
`define RFPMC_PW_BASE_16      6'h05
`define RFPMC_PW_FOLD_64      6'h1A

`endif

// >>> design/rfpmc_pkg.sv
// Types shared by the protocol mode configuration block
package rfpmc_pkg;

    typedef enum logic [3:0] {
        PM_NFC_ACTIVE,
        PM_TYPE_A,
        PM_TYPE_B,
        PM_NFCF_READER,
        PM_TYPE1_TAG,
        PM_SUBC_STREAM,
        PM_BPSK_STREAM,
        PM_TGT_RATE_DETECT,
        PM_TGT_NORMAL,
        PM_UNUSED
    } rfpmc_mode_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } rfpmc_ahb_in_t;

    typedef struct packed {
        rfpmc_mode_t mode;
        logic        role_target;
        logic        txrx_enable;
        logic [3:0]  tx_rate;
        logic [3:0]  rx_rate;
        logic [5:0]  pulse_periods;
        logic        tx_parity_off;
        logic        rx_raw;
        logic        transport_frame;
        logic [7:0]  frame_start_byte;
        logic        anticoll_frame;
        logic        collision_avoid_start;
    } rfpmc_cfg_t;

endpackage

// >>> design/rfpmc_top.sv
// Protocol mode, link rate and type A framing registers behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "rfpmc_params.svh"

module rfpmc_top
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // AHB-Lite slave
    input  wire rfpmc_pkg::rfpmc_ahb_in_t ahb_in,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Commands from the command decoder
    input  wire logic             set_default_cmd,
    input  wire logic             normal_nfc_entry_command,
    input  wire logic [7:0]       detected_rate_code,
    // RF field detector pin
    input  wire logic             ext_field_on,
    // Settings toward the framing logic
    output var rfpmc_pkg::rfpmc_cfg_t cfg
);
    import rfpmc_pkg::*;

    typedef struct packed {
        logic [7:0]  mode_reg;
        logic [7:0]  rate_reg;
        logic [7:0]  typea_reg;
        logic        wr_pend;
        logic [5:0]  wr_idx;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
        logic        field_s1;
        logic        field_s2;
        logic        field_prev;
        rfpmc_cfg_t  cfg;
    } rfpmc_state_t;

    rfpmc_state_t q;
    rfpmc_state_t d;

    // Role and mode field to protocol
    function automatic rfpmc_mode_t decode_mode(input logic role, input logic [3:0] om);
        rfpmc_mode_t m;
        m = PM_UNUSED;
        if (role)
        begin
            if (om == 4'h0)
                m = PM_TGT_RATE_DETECT;                            // RULE_03
            else if (om == 4'h1)
                m = PM_TGT_NORMAL;                                 // RULE_03
        end
        else
        begin
            unique case (om)                                       // RULE_02
                4'h0:    m = PM_NFC_ACTIVE;
                4'h1:    m = PM_TYPE_A;
                4'h2:    m = PM_TYPE_B;
                4'h3:    m = PM_NFCF_READER;
                4'h4:    m = PM_TYPE1_TAG;
                4'hE:    m = PM_SUBC_STREAM;
                4'hF:    m = PM_BPSK_STREAM;
                default: m = PM_UNUSED;
            endcase
        end
        return m;
    endfunction

    function automatic logic rate_ok(input logic [3:0] r);
        return r <= `RFPMC_RATE_MAX;                               // RULE_09
    endfunction

    // Pulse code is a signed offset around a per-rate base, folded back for codes 5 and 6 at rate code 1; out-of-range codes give 0
    function automatic logic [5:0] pulse_periods(input logic [3:0] code, input logic [3:0] r);
        logic [5:0] w;
        logic [5:0] sx;
        int         s;
        w  = 6'h00;
        sx = {{2{code[3]}}, code};
        s  = code[3] ? int'(code) - 16 : int'(code);
        unique case (r)                                            // RULE_18
            4'h0: w = 6'(`RFPMC_PW_BASE_128 + sx);
            4'h1:
            begin
                if (s >= -6 && s <= 4)
                    w = 6'(`RFPMC_PW_BASE_64 + sx);
                else if (s == 5 || s == 6)
                    w = 6'(`RFPMC_PW_FOLD_64 - sx);
            end
            4'h2:
            begin
                if (s >= -4 && s <= 4)
                    w = 6'(`RFPMC_PW_BASE_32 + sx);
            end
            4'h3:
            begin
                if (s >= -3 && s <= 3)
                    w = 6'(`RFPMC_PW_BASE_16 + sx);
            end
            default: w = 6'h00;
        endcase
        return w;
    endfunction

    function automatic logic [7:0] read_reg(input logic [5:0] idx, input logic [7:0] m,
                                            input logic [7:0] r, input logic [7:0] t);
        logic [7:0] v;
        v = 8'h00;
        if (idx == `RFPMC_IDX_MODE)
            v = m;
        else if (idx == `RFPMC_IDX_RATE)
            v = r;
        else if (idx == `RFPMC_IDX_TYPEA)
            v = t;
        return v;
    endfunction

    logic        addr_phase;
    logic [5:0]  addr_idx;
    logic        in_page;
    rfpmc_mode_t mode_now;
    logic        split_rate_ok;
    logic        active_nfc;
    logic [3:0]  rx_eff;

    always_comb
    begin
        d = q;

        addr_phase = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
        addr_idx   = ahb_in.haddr[7:2];
        in_page    = (ahb_in.haddr[31:8] == 24'h000000);

        // Data phase write lands first so a read right behind it sees the new value
        if (q.wr_pend)
        begin
            if (q.wr_idx == `RFPMC_IDX_MODE)
                d.mode_reg = ahb_in.hwdata[7:0] & `RFPMC_MODE_WMASK;   // RULE_19
            else if (q.wr_idx == `RFPMC_IDX_RATE)
                d.rate_reg = ahb_in.hwdata[7:0];
            else if (q.wr_idx == `RFPMC_IDX_TYPEA)
                d.typea_reg = ahb_in.hwdata[7:0];
        end
        if (normal_nfc_entry_command)
            d.rate_reg = detected_rate_code;                       // RULE_11
        if (set_default_cmd)
        begin
            d.mode_reg  = `RFPMC_MODE_RST;                         // RULE_06
            d.rate_reg  = `RFPMC_RATE_RST;
            d.typea_reg = `RFPMC_TYPEA_RST;
        end

        // Unmapped addresses read zero and take no write; every answer is OKAY
        d.wr_pend   = addr_phase && ahb_in.hwrite && in_page;
        d.wr_idx    = addr_idx;
        d.hreadyout = 1'b1;
        d.hresp     = 1'b0;
        if (addr_phase && !ahb_in.hwrite)
            d.hrdata = in_page ? {24'h000000,
                                  read_reg(addr_idx, d.mode_reg, d.rate_reg, d.typea_reg)}
                               : 32'h00000000;

        d.field_s1   = ext_field_on;
        d.field_s2   = q.field_s1;
        d.field_prev = q.field_s2;

        mode_now      = decode_mode(q.mode_reg[`RFPMC_MODE_ROLE_BIT], q.mode_reg[6:3]); // RULE_01
        split_rate_ok = (mode_now == PM_TYPE_A) || (mode_now == PM_TYPE_B);
        active_nfc    = (mode_now == PM_NFC_ACTIVE) || (mode_now == PM_TGT_RATE_DETECT)
                        || (mode_now == PM_TGT_NORMAL);
        rx_eff        = split_rate_ok ? q.rate_reg[3:0] : q.rate_reg[7:4];   // RULE_08

        d.cfg.mode        = mode_now;
        d.cfg.role_target = q.mode_reg[`RFPMC_MODE_ROLE_BIT];
        d.cfg.tx_rate     = q.rate_reg[7:4];                       // RULE_07
        d.cfg.rx_rate     = rx_eff;
        d.cfg.txrx_enable = (mode_now != PM_UNUSED)                // RULE_04
                            && rate_ok(q.rate_reg[7:4]) && rate_ok(rx_eff);  // RULE_10
        d.cfg.pulse_periods = pulse_periods(q.typea_reg[4:1], q.rate_reg[7:4]); // RULE_16
        d.cfg.tx_parity_off = q.typea_reg[`RFPMC_TA_NOTXPAR_BIT];  // RULE_12
        d.cfg.rx_raw        = q.typea_reg[`RFPMC_TA_NORXPAR_BIT];  // RULE_14
        d.cfg.transport_frame = q.typea_reg[`RFPMC_TA_TFRAME_BIT] && active_nfc; // RULE_15
        d.cfg.frame_start_byte = `RFPMC_START_BYTE;                // RULE_15
        d.cfg.anticoll_frame   = q.typea_reg[`RFPMC_TA_ANTCL_BIT];
        // Fall seen on synchronised copies only; the pin itself may glitch
        d.cfg.collision_avoid_start = q.field_prev && !q.field_s2
                                      && q.mode_reg[`RFPMC_MODE_AUTO_BIT];   // RULE_05
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            q           <= '0;
            q.mode_reg  <= `RFPMC_MODE_RST;                        // RULE_06
            q.rate_reg  <= `RFPMC_RATE_RST;
            q.typea_reg <= `RFPMC_TYPEA_RST;
            q.hreadyout <= 1'b1;
            q.cfg.mode  <= PM_UNUSED;
            q.cfg.frame_start_byte <= `RFPMC_START_BYTE;
        end
        else
        begin
            q <= d;
        end
    end

    assign hrdata    = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp     = q.hresp;
    assign cfg       = q.cfg;

    property p_defaults;
        @(posedge sys_clk) disable iff (srst)
        $past(set_default_cmd) |-> (q.mode_reg == `RFPMC_MODE_RST)
            && (q.rate_reg == `RFPMC_RATE_RST) && (q.typea_reg == `RFPMC_TYPEA_RST);
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not restored"); // RULE_06

    property p_unused_bits;
        @(posedge sys_clk) disable iff (srst)
        q.mode_reg[2:1] == 2'b00;
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("mode bits 2:1 not zero"); // RULE_19

    property p_bad_mode_off;
        @(posedge sys_clk) disable iff (srst)
        (q.cfg.mode == PM_UNUSED) |-> !q.cfg.txrx_enable;
    endproperty
    a_bad_mode_off: assert property (p_bad_mode_off) else $error("unused mode left on"); // RULE_04

    property p_bad_rate_off;
        @(posedge sys_clk) disable iff (srst)
        (q.rate_reg[7:4] > `RFPMC_RATE_MAX) |=> !q.cfg.txrx_enable;
    endproperty
    a_bad_rate_off: assert property (p_bad_rate_off) else $error("bad rate left on"); // RULE_10

    property p_entry_load;
        @(posedge sys_clk) disable iff (srst)
        (normal_nfc_entry_command && !set_default_cmd)
            |=> (q.rate_reg == $past(detected_rate_code));
    endproperty
    a_entry_load: assert property (p_entry_load) else $error("rate not loaded"); // RULE_11

    property p_target_normal;
        @(posedge sys_clk) disable iff (srst)
        (q.mode_reg[7:3] == 5'h11) |=> (q.cfg.mode == PM_TGT_NORMAL);
    endproperty
    a_target_normal: assert property (p_target_normal) else $error("target decode"); // RULE_03

    property p_initiator_a;
        @(posedge sys_clk) disable iff (srst)
        (q.mode_reg[7:3] == 5'h01) |=> (q.cfg.mode == PM_TYPE_A) && !q.cfg.role_target;
    endproperty
    a_initiator_a: assert property (p_initiator_a) else $error("initiator decode"); // RULE_02

    property p_rx_follows_tx;
        @(posedge sys_clk) disable iff (srst)
        (q.cfg.mode != PM_TYPE_A && q.cfg.mode != PM_TYPE_B)
            |-> (q.cfg.rx_rate == q.cfg.tx_rate);
    endproperty
    a_rx_follows_tx: assert property (p_rx_follows_tx) else $error("rx rate split"); // RULE_08

    property p_pulse_slow;
        @(posedge sys_clk) disable iff (srst)
        (q.rate_reg[7:4] == 4'h0 && q.typea_reg[4:1] == 4'h0)
            |=> (q.cfg.pulse_periods == 6'h23);
    endproperty
    a_pulse_slow: assert property (p_pulse_slow) else $error("pulse width at fc/128"); // RULE_18

    property p_pulse_fast;
        @(posedge sys_clk) disable iff (srst)
        (q.rate_reg[7:4] == 4'h3 && q.typea_reg[4:1] == 4'h0)
            |=> (q.cfg.pulse_periods == 6'h05);
    endproperty
    a_pulse_fast: assert property (p_pulse_fast) else $error("pulse width at fc/16"); // RULE_16

    property p_parity_flags;
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> (q.cfg.tx_parity_off == $past(q.typea_reg[7]))
            && (q.cfg.rx_raw == $past(q.typea_reg[6]));
    endproperty
    a_parity_flags: assert property (p_parity_flags) else $error("parity flags lag"); // RULE_12

    property p_frame_active_only;
        @(posedge sys_clk) disable iff (srst)
        q.cfg.transport_frame |-> q.cfg.mode inside {PM_NFC_ACTIVE, PM_TGT_RATE_DETECT,
            PM_TGT_NORMAL} && q.cfg.frame_start_byte == `RFPMC_START_BYTE;
    endproperty
    a_frame_active_only: assert property (p_frame_active_only) else $error("frame mode"); // RULE_15

    property p_ca_start;
        @(posedge sys_clk) disable iff (srst)
        (q.mode_reg[0] && $fell(q.field_s2)) |=> q.cfg.collision_avoid_start ##1
            !q.cfg.collision_avoid_start;
    endproperty
    a_ca_start: assert property (p_ca_start) else $error("collision avoid start"); // RULE_05

    // Auto bit clear must keep the start pulse low whatever the field does
    property p_ca_quiet;
        @(posedge sys_clk) disable iff (srst)
        !q.mode_reg[`RFPMC_MODE_AUTO_BIT] |=> !q.cfg.collision_avoid_start;
    endproperty
    a_ca_quiet: assert property (p_ca_quiet) else $error("collision avoid without auto"); // RULE_05

    property p_role;
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> (q.cfg.role_target == $past(q.mode_reg[`RFPMC_MODE_ROLE_BIT]));
    endproperty
    a_role: assert property (p_role) else $error("role bit not followed"); // RULE_01

    property p_tx_rate;
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> (q.cfg.tx_rate == $past(q.rate_reg[7:4]));
    endproperty
    a_tx_rate: assert property (p_tx_rate) else $error("tx rate not upper nibble"); // RULE_07

    property p_rx_split;
        @(posedge sys_clk) disable iff (srst)
        (q.mode_reg[7:3] == 5'h01) |=> (q.cfg.rx_rate == $past(q.rate_reg[3:0]));
    endproperty
    a_rx_split: assert property (p_rx_split) else $error("rx rate not lower nibble"); // RULE_08

    property p_good_rate_on;
        @(posedge sys_clk) disable iff (srst)
        (q.mode_reg[7:3] == 5'h01 && q.rate_reg[7:4] <= `RFPMC_RATE_MAX
            && q.rate_reg[3:0] <= `RFPMC_RATE_MAX) |=> q.cfg.txrx_enable;
    endproperty
    a_good_rate_on: assert property (p_good_rate_on) else $error("valid rate disabled"); // RULE_09

    property p_init_unused;
        @(posedge sys_clk) disable iff (srst)
        (!q.mode_reg[7] && q.mode_reg[6:3] > 4'h4 && q.mode_reg[6:3] < 4'hE)
            |=> (q.cfg.mode == PM_UNUSED) && !q.cfg.txrx_enable;
    endproperty
    a_init_unused: assert property (p_init_unused) else $error("unused initiator code on"); // RULE_04

    property p_tgt_unused;
        @(posedge sys_clk) disable iff (srst)
        (q.mode_reg[7] && q.mode_reg[6:4] != 3'h0) |=> (q.cfg.mode == PM_UNUSED);
    endproperty
    a_tgt_unused: assert property (p_tgt_unused) else $error("unused target code decoded"); // RULE_03

    // A bus write to the mode word must land with bits 2:1 forced low
    property p_mode_write;
        @(posedge sys_clk) disable iff (srst)
        (q.wr_pend && q.wr_idx == `RFPMC_IDX_MODE && !set_default_cmd)
            |=> (q.mode_reg == ($past(ahb_in.hwdata[7:0]) & `RFPMC_MODE_WMASK));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write not masked"); // RULE_19

endmodule // rfpmc_top

`default_nettype wire

// >>> verification/rfpmc_field_model.sv
// Far-side field source that drives the external field detector pin
`timescale 1ns/1ps
`default_nettype none

module rfpmc_field_model
#(
    parameter int SKEW_NS = 3
)
(
    // Clock and request
    input  wire logic sys_clk,
    input  wire logic field_req,
    // Field detector pin
    output logic      ext_field_on
);
    // Skewed off the edge so the pin looks asynchronous to the block
    always @(posedge sys_clk)
        ext_field_on <= #(SKEW_NS) field_req;
endmodule // rfpmc_field_model

`default_nettype wire

// >>> verification/rfpmc_tb.sv
// Self-checking bench for the protocol mode, link rate and type A registers
`timescale 1ns/1ps
`default_nettype none
`include "rfpmc_params.svh"

module testbench;
    import rfpmc_pkg::*;

    logic          sys_clk;
    logic          srst;
    logic          hsel;
    logic          hwrite;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    logic [31:0]   haddr;
    logic [31:0]   hwdata;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    logic          set_default_cmd;
    logic          normal_nfc_entry_command;
    logic [7:0]    detected_rate_code;
    logic          field_req;
    logic          ext_field_on;
    rfpmc_ahb_in_t ahb_in;
    rfpmc_cfg_t    cfg;
    logic [7:0]    m_img;
    logic [7:0]    r_img;
    logic [7:0]    t_img;
    logic [7:0]    code_v;
    int            errors;
    int            tests_run;
    int            pulse_cnt = 0;
    int            ca_base;

    assign ahb_in = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                      hsize: hsize, hready: hreadyout, hwdata: hwdata};

    rfpmc_top i_dut (
        .sys_clk                  (sys_clk),
        .srst                     (srst),
        .ahb_in                   (ahb_in),
        .hrdata                   (hrdata),
        .hreadyout                (hreadyout),
        .hresp                    (hresp),
        .set_default_cmd          (set_default_cmd),
        .normal_nfc_entry_command (normal_nfc_entry_command),
        .detected_rate_code       (detected_rate_code),
        .ext_field_on             (ext_field_on),
        .cfg                      (cfg)
    );

    rfpmc_field_model i_field (
        .sys_clk      (sys_clk),
        .field_req    (field_req),
        .ext_field_on (ext_field_on)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Sampled mid-cycle, away from the launching edge
    always @(negedge sys_clk)
        if (cfg.collision_avoid_start === 1'b1)
            pulse_cnt = pulse_cnt + 1;

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic rfpmc_cfg_t exp_cfg(input logic [7:0] m, input logic [7:0] r,
                                           input logic [7:0] t);
        rfpmc_cfg_t c;
        int         s;
        c = '0;
        s = $signed(t[4:1]);
        c.role_target = m[7];
        if (m[7])
            c.mode = (m[6:3] == 4'h0) ? PM_TGT_RATE_DETECT :
                     (m[6:3] == 4'h1) ? PM_TGT_NORMAL : PM_UNUSED;
        else
            case (m[6:3])
                4'h0: c.mode = PM_NFC_ACTIVE;
                4'h1: c.mode = PM_TYPE_A;
                4'h2: c.mode = PM_TYPE_B;
                4'h3: c.mode = PM_NFCF_READER;
                4'h4: c.mode = PM_TYPE1_TAG;
                4'hE: c.mode = PM_SUBC_STREAM;
                4'hF: c.mode = PM_BPSK_STREAM;
                default: c.mode = PM_UNUSED;
            endcase
        c.tx_rate = r[7:4];
        c.rx_rate = (c.mode == PM_TYPE_A || c.mode == PM_TYPE_B) ? r[3:0] : r[7:4];
        c.txrx_enable = c.mode != PM_UNUSED && r[7:4] <= 4'h3 && c.rx_rate <= 4'h3;
        // Width table folds back at the top of rate code 1 (fc/64) only
        case (r[7:4])
            4'h0: c.pulse_periods = 6'(35 + s);
            4'h1: c.pulse_periods = (s >= -6 && s <= 4) ? 6'(18 + s) :
                                    (s >= 5 && s <= 6) ? 6'(26 - s) : 6'h00;
            4'h2: c.pulse_periods = (s >= -4 && s <= 4) ? 6'(9 + s) : 6'h00;
            4'h3: c.pulse_periods = (s >= -3 && s <= 3) ? 6'(5 + s) : 6'h00;
            default: c.pulse_periods = 6'h00;
        endcase
        c.tx_parity_off = t[7];
        c.rx_raw = t[6];
        c.anticoll_frame = t[0];
        c.transport_frame = t[5] && (c.mode inside {PM_NFC_ACTIVE, PM_TGT_RATE_DETECT,
                                                     PM_TGT_NORMAL});
        c.frame_start_byte = 8'hF0;
        return c;
    endfunction

    task automatic wait_ready();
        int n;
        for (n = 0; n < 16; n++)
        begin
            @(posedge sys_clk);
            if (hreadyout === 1'b1)
                break;
        end
        if (n == 16)
        begin
            errors++;
            close_out();
        end
    endtask

    // Entered right after a rising edge; returns at the data phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h00000000, {31'h00000000, hresp});
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v;
        bus(1'b0, {24'h000000, a}, 32'h00000000, v);
        chk(what, {24'h000000, e}, v);
    endtask

    task automatic chk_cfg();
        rfpmc_cfg_t e;
        e = exp_cfg(m_img, r_img, t_img);
        @(negedge sys_clk);
        tests_run++;
        if (cfg !== e)
        begin
            errors++;
            $display("mismatch cfg expected %h seen %h", e, cfg);
        end
        @(posedge sys_clk);
    endtask

    task automatic check_all();
        rd_chk("protocol_mode_select", `RFPMC_ADDR_MODE, m_img);
        rd_chk("link_rate_select", `RFPMC_ADDR_RATE, r_img);
        rd_chk("type_a_framing_settings", `RFPMC_ADDR_TYPEA, t_img);
        chk_cfg();
    endtask

    task automatic set_regs(input logic [7:0] m, input logic [7:0] r, input logic [7:0] t);
        logic [31:0] v;
        bus(1'b1, {24'h000000, `RFPMC_ADDR_MODE}, {24'h000000, m}, v);
        bus(1'b1, {24'h000000, `RFPMC_ADDR_RATE}, {24'h000000, r}, v);
        bus(1'b1, {24'h000000, `RFPMC_ADDR_TYPEA}, {24'h000000, t}, v);
        m_img = m & `RFPMC_MODE_WMASK;
        r_img = r;
        t_img = t;
    endtask

    initial
    begin
        logic [31:0] v;
        srst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        set_default_cmd = 1'b0;
        normal_nfc_entry_command = 1'b0;
        detected_rate_code = 8'h00;
        field_req = 1'b1;
        errors = 0;
        tests_run = 0;
        void'($urandom(17));
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        m_img = `RFPMC_MODE_RST;
        r_img = 8'h00;
        t_img = 8'h00;
        check_all();
        // Every role and mode code, with the unused bits written high
        for (int i = 0; i < 32; i++)
        begin
            set_regs({i[4], i[3:0], 3'h6}, 8'h00, 8'h20);
            check_all();
        end
        // Every pulse code at rate codes 0 to 5, including unused codes 4 and 5, mixed with random modes
        for (int i = 0; i < 96; i++)
        begin
            set_regs((i % 2) ? 8'h08 : 8'($urandom), {4'(i / 16), 4'($urandom % 5)},
                     {3'($urandom), 4'(i % 16), 1'($urandom)});
            check_all();
        end
        // Writes outside the map leave the registers alone and read zero
        bus(1'b1, 32'h0000010C, 32'h000000FF, v);
        bus(1'b1, 32'h00000018, 32'h000000FF, v);
        rd_chk("unmapped", 8'h18, 8'h00);
        check_all();
        set_regs(8'hB9, 8'h33, 8'hE1);
        set_default_cmd <= 1'b1;
        @(posedge sys_clk);
        set_default_cmd <= 1'b0;
        @(posedge sys_clk);
        m_img = `RFPMC_MODE_RST;
        r_img = 8'h00;
        t_img = 8'h00;
        check_all();
        for (int k = 0; k < 6; k++)
        begin
            code_v = (k == 0) ? 8'h30 : 8'($urandom);
            detected_rate_code <= code_v;
            normal_nfc_entry_command <= 1'b1;
            @(posedge sys_clk);
            normal_nfc_entry_command <= 1'b0;
            @(posedge sys_clk);
            r_img = code_v;
            check_all();
        end
        // Field drop with the automatic bit clear, then set
        for (int a = 0; a < 2; a++)
        begin
            set_regs(8'h08 | 8'(a), 8'h00, 8'h00);
            ca_base = pulse_cnt;
            field_req <= 1'b0;
            repeat (10) @(posedge sys_clk);
            field_req <= 1'b1;
            repeat (8) @(posedge sys_clk);
            chk("collision_avoid_start", 32'(a), 32'(pulse_cnt - ca_base));
        end
        close_out();
    end
endmodule // testbench

`default_nettype wire
